// ---- dv/icsc_cpu_model.sv ----
// Purpose: Behavioural core side: takes interrupt requests
// Assumes: Same clock as the block, one ack per request
// Notes:   Wait before ack is set by the bench, zero is prompt
`timescale 1ns/1ps

module icsc_cpu_model (
  // Clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_n,
  // Request link
  input wire logic       irqReq,
  input wire logic [3:0] ackDly,
  output logic           irqAck
);
  logic [3:0] waitCnt;

  // Ack after the programmed wait; the ack pulse forces a gap before the next
  always @(posedge ref_clk)
  begin
    if (!rst_n || irqAck)
    begin
      irqAck  <= 1'b0;
      waitCnt <= 4'h0;
    end
    else if (irqReq && waitCnt >= ackDly)
      irqAck <= 1'b1;
    else if (irqReq)
      waitCnt <= waitCnt + 4'h1;
    else
      waitCnt <= 4'h0;
  end
endmodule // icsc_cpu_model

// ---- dv/icsc_interrupt_control_status_tb.sv ----
// Purpose: Self-checking bench for the interrupt control block
// Assumes: Core model acks requests; bench drives bus, pins and events
// Notes:   Trap levels follow the block's own level table
`timescale 1ns/1ps
`include "icsc_consts.vh"

module icsc_interrupt_control_status_tb;
  logic        ref_clk = 1'b0;
  logic        rst_n = 1'b0;
  logic        wbCyc = 1'b0, wbStb = 1'b0, wbWe = 1'b0, disable_instr_active = 1'b0, altOk = 1'b0;
  logic [7:0]  wbAdr = 8'h00;
  logic [31:0] wbDatI = 32'h0, wbDatO;
  logic        wbAck, irqReq, irqAck, useAlt, lvlLoad = 1'b0;
  logic [4:0]  extPin = 5'h00;
  logic [15:0] srcEvt = 16'h0000, rd;
  logic [6:0]  trapEvt = 7'h00;
  logic [3:0]  lvlIn = 4'h0, ackDly = 4'h0, irqLevel, cpuLevel, ackLvl;
  logic [7:0]  irqVector, ackVec;
  int          error_cnt = 0, num_checks = 0, ackCnt = 0;
  // Trap table: math, addr, stack, osc, deadman, ecc, sw hard
  logic [7:0]  tAdr [7] = '{`ICSC_ADR_INT_CTRL1, `ICSC_ADR_INT_CTRL1, `ICSC_ADR_INT_CTRL1,
    `ICSC_ADR_INT_CTRL1, `ICSC_ADR_INT_CTRL3, `ICSC_ADR_INT_CTRL4, `ICSC_ADR_INT_CTRL4};
  logic [15:0] tBit [7] = '{16'h0010, 16'h0008, 16'h0004, 16'h0002, 16'h8000, 16'h0002, 16'h0001};
  logic [7:0]  tVec [7] = '{8'h04, 8'h01, 8'h03, 8'h00, 8'h06, 8'h02, 8'h02};
  logic [3:0]  tLvl [7] = '{4'hb, 4'he, 4'hc, 4'hf, 4'h8, 4'hd, 4'hd};

  always #20 ref_clk = ~ref_clk;

  icsc_interrupt_control_status icsc_interrupt_control_status_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
    .wb_adr_i(wbAdr), .wb_sel_i(4'hf), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
    .extIrqPin(extPin), .srcEvent(srcEvt), .mathTrapEvt(trapEvt[0]), .addrTrapEvt(trapEvt[1]),
    .stackTrapEvt(trapEvt[2]), .oscTrapEvt(trapEvt[3]), .deadmanTrapEvt(trapEvt[4]),
    .eccTrapEvt(trapEvt[5]), .swHardTrapEvt(trapEvt[6]), .disiActive(disable_instr_active),
    .altTableAllowed(altOk), .irqAck(irqAck), .cpuLevelLoad(lvlLoad), .cpuLevelIn(lvlIn),
    .irqReq(irqReq), .irqVector(irqVector), .irqLevel(irqLevel), .cpuLevel(cpuLevel),
    .useAltTable(useAlt));

  icsc_cpu_model icsc_cpu_model_i (
    .ref_clk(ref_clk), .rst_n(rst_n), .irqReq(irqReq), .ackDly(ackDly), .irqAck(irqAck));

  // Record what the core took, at the taking edge
  always @(posedge ref_clk)
    if (irqReq === 1'b1 && irqAck === 1'b1)
    begin
      ackCnt <= ackCnt + 1;
      ackVec <= irqVector;
      ackLvl <= irqLevel;
    end

  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("unexpected %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  // Classic single cycle; held until ack is sampled, then released
  task automatic wbx(input logic [7:0] a, input logic w, input logic [15:0] d);
    int n;
    @(posedge ref_clk);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= a;
    wbDatI <= {16'h0000, d};
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (wbAck !== 1'b1 && n < 16);
    if (n >= 16)
      error_cnt++;
    rd = wbDatO[15:0];
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    wbWe <= 1'b0;
  endtask

  task automatic rdchk(input string nm, input logic [7:0] a, input logic [15:0] e);
    wbx(a, 1'b0, 16'h0000);
    chk(nm, rd, e);
  endtask

  task automatic pulse(input logic [15:0] s);
    srcEvt <= s;
    @(posedge ref_clk);
    srcEvt <= 16'h0000;
  endtask

  // Core returns from the handler and restores a level
  task automatic loadLvl(input logic [3:0] l);
    @(posedge ref_clk);
    lvlLoad <= 1'b1;
    lvlIn <= l;
    @(posedge ref_clk);
    lvlLoad <= 1'b0;
  endtask

  task automatic expAck(input logic [7:0] v, input logic [3:0] l);
    expAckCpu(v, l, l);
  endtask

  // Wait for the core to take a request; c is the level the CPU moves to
  task automatic expAckCpu(input logic [7:0] v, input logic [3:0] l, input logic [3:0] c);
    int c0, n;
    c0 = ackCnt;
    n = 0;
    while (ackCnt == c0 && n < 40)
    begin
      @(posedge ref_clk);
      n++;
    end
    if (n >= 40)
      error_cnt++;
    chk("ackVec", {8'h00, ackVec}, {8'h00, v});
    chk("ackLvl", {12'h000, ackLvl}, {12'h000, l});
    chk("cpuLevel", {12'h000, cpuLevel}, {12'h000, c});
  endtask

  task automatic expNone;
    int c0;
    c0 = ackCnt;
    repeat (20) @(posedge ref_clk);
    chk("ackNone", 16'(ackCnt - c0), 16'h0000);
  endtask

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, error_cnt);
    if (error_cnt == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // Watchdog well beyond the expected run of a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge ref_clk);
    error_cnt++;
    report_and_stop;
  end

  initial
  begin
    repeat (6) @(posedge ref_clk);
    rst_n <= 1'b1;
    rdchk("ctrl2", `ICSC_ADR_INT_CTRL2, 16'h8000);
    rdchk("ctrl1", `ICSC_ADR_INT_CTRL1, 16'h0000);
    rdchk("coreCtrl", `ICSC_ADR_CORE_CTRL, 16'h0000);
    wbx(`ICSC_ADR_INT_CTRL4, 1'b1, 16'h0003);
    rdchk("ctrl4", `ICSC_ADR_INT_CTRL4, 16'h0000);
    rdchk("unmapped", 8'hfc, 16'h0000);
    wbx(`ICSC_ADR_INT_CTRL1, 1'b1, 16'h8000);
    rdchk("ctrl1", `ICSC_ADR_INT_CTRL1, 16'h8000);
    wbx(`ICSC_ADR_ALU_STATUS, 1'b1, 16'h00e0);
    @(posedge ref_clk);
    chk("lvlLocked", {12'h000, cpuLevel}, 16'h0000);
    wbx(`ICSC_ADR_INT_CTRL1, 1'b1, 16'h0000);
    wbx(`ICSC_ADR_ALU_STATUS, 1'b1, 16'h00e0);
    @(posedge ref_clk);
    chk("lvlWrite", {12'h000, cpuLevel}, 16'h0007);
    wbx(`ICSC_ADR_CORE_CTRL, 1'b1, 16'h0008);
    rdchk("msbNoSet", `ICSC_ADR_CORE_CTRL, 16'h0000);
    wbx(`ICSC_ADR_INT_CTRL2, 1'b1, 16'hc11f);
    rdchk("ctrl2", `ICSC_ADR_INT_CTRL2, 16'h811f);
    disable_instr_active <= 1'b1;
    altOk <= 1'b1;
    rdchk("disable_instr_active", `ICSC_ADR_INT_CTRL2, 16'hc11f);
    chk("altOn", {15'h0, useAlt}, 16'h0001);
    altOk <= 1'b0;
    @(posedge ref_clk);
    chk("altGate", {15'h0, useAlt}, 16'h0000);
    altOk <= 1'b1;
    wbx(`ICSC_ADR_INT_CTRL2, 1'b1, 16'h8000);
    @(posedge ref_clk);
    chk("altOff", {15'h0, useAlt}, 16'h0000);
    altOk <= 1'b0;
    disable_instr_active <= 1'b0;
    $display("test registers done");
    // Sources 0..3 at priority 7, 5, 5, 0; level 7 holds them off
    wbx(`ICSC_ADR_PRIO0, 1'b1, 16'h0557);
    wbx(`ICSC_ADR_ENABLE0, 1'b1, 16'h0007);
    pulse(16'h0001);
    expNone;
    wbx(`ICSC_ADR_ALU_STATUS, 1'b1, 16'h0000);
    expAck(8'h08, 4'h7);
    wbx(`ICSC_ADR_FLAG0, 1'b1, 16'h0000);
    loadLvl(4'h0);
    pulse(16'h0006);
    expAck(8'h09, 4'h5);
    rdchk("flags", `ICSC_ADR_FLAG0, 16'h0006);
    rdchk("vecStat", `ICSC_ADR_VEC_STATUS, 16'h8509);
    wbx(`ICSC_ADR_FLAG0, 1'b1, 16'h0004);
    // Capture select on: live pending vector instead of last taken
    wbx(`ICSC_ADR_VEC_STATUS, 1'b1, 16'h2000);
    rdchk("vecLive", `ICSC_ADR_VEC_STATUS, 16'ha50a);
    wbx(`ICSC_ADR_VEC_STATUS, 1'b1, 16'h0000);
    loadLvl(4'h0);
    expAck(8'h0a, 4'h5);
    wbx(`ICSC_ADR_FLAG0, 1'b1, 16'h0000);
    loadLvl(4'h0);
    wbx(`ICSC_ADR_INT_CTRL2, 1'b1, 16'h0000);
    pulse(16'h0002);
    expNone;
    wbx(`ICSC_ADR_INT_CTRL2, 1'b1, 16'h8000);
    expAck(8'h09, 4'h5);
    wbx(`ICSC_ADR_FLAG0, 1'b1, 16'h0000);
    loadLvl(4'h0);
    pulse(16'h0010);
    expNone;
    rdchk("flagOnly", `ICSC_ADR_FLAG0, 16'h0010);
    // Nesting off: a taken user request lifts the CPU to level 7
    wbx(`ICSC_ADR_INT_CTRL1, 1'b1, 16'h8000);
    pulse(16'h0002);
    expAckCpu(8'h09, 4'h5, 4'h7);
    wbx(`ICSC_ADR_INT_CTRL1, 1'b1, 16'h0000);
    wbx(`ICSC_ADR_FLAG0, 1'b1, 16'h0000);
    loadLvl(4'h0);
    $display("test user sources done");
    // Pins 0 and 1 on opposite edges, no enables
    wbx(`ICSC_ADR_ENABLE0, 1'b1, 16'h0000);
    wbx(`ICSC_ADR_FLAG0, 1'b1, 16'h0000);
    wbx(`ICSC_ADR_INT_CTRL2, 1'b1, 16'h8001);
    extPin <= 5'h03;
    repeat (6) @(posedge ref_clk);
    rdchk("pinRise", `ICSC_ADR_FLAG0, 16'h0002);
    extPin <= 5'h00;
    repeat (6) @(posedge ref_clk);
    rdchk("pinFall", `ICSC_ADR_FLAG0, 16'h0003);
    wbx(`ICSC_ADR_FLAG0, 1'b1, 16'h0000);
    $display("test pins done");
    // Traps with the global enable off and a slow core
    wbx(`ICSC_ADR_INT_CTRL2, 1'b1, 16'h0000);
    ackDly <= 4'h5;
    for (int i = 0; i < 7; i++)
    begin
      trapEvt <= 7'(1 << i);
      @(posedge ref_clk);
      trapEvt <= 7'h00;
      expAck(tVec[i], tLvl[i]);
      rdchk("trapFlag", tAdr[i], tBit[i]);
      wbx(tAdr[i], 1'b1, 16'h0000);
      rdchk("trapClr", tAdr[i], 16'h0000);
      loadLvl(4'h0);
    end
    wbx(`ICSC_ADR_INT_CTRL2, 1'b1, 16'h2000);
    expAck(`ICSC_VEC_SOFT, 4'h8);
    wbx(`ICSC_ADR_INT_CTRL2, 1'b1, 16'h8000);
    // Software may clear the level high bit
    wbx(`ICSC_ADR_CORE_CTRL, 1'b1, 16'h0000);
    @(posedge ref_clk);
    chk("msbClear", {12'h000, cpuLevel}, 16'h0000);
    $display("test traps done");
    report_and_stop;
  end
endmodule // icsc_interrupt_control_status_tb

// ---- dv/icsc_props.sv ----
// Purpose: Port-level checks of the interrupt control block
// Assumes: One clock, synchronous active-low reset
// Notes:   Bound to every instance of the block
`timescale 1ns/1ps

module icsc_props (
  // Clock and reset
  input wire logic        ref_clk,
  input wire logic        rst_n,
  // Bus
  input wire logic        wb_cyc_i,
  input wire logic        wb_stb_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic        wb_ack_o,
  // Core link
  input wire logic        irqAck,
  input wire logic        irqReq,
  input wire logic [7:0]  irqVector,
  input wire logic [3:0]  irqLevel,
  input wire logic [3:0]  cpuLevel
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // Bus answers one cycle after a fresh request, as a single pulse
  a_ack_after_req: assert property ((wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
    else $error("ack missing after request");
  a_ack_single: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_has_cause: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
    else $error("ack without request");
  a_upper_half_zero: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0000)
    else $error("upper read half not zero");
  // Request must stand above the level it was judged against
  a_req_above_level: assert property (irqReq |-> irqLevel > $past(cpuLevel))
    else $error("request not above cpu level");
  a_vec_level_pair: assert property (irqReq |-> (irqVector < 8'h08) == irqLevel[3])
    else $error("trap vector and level disagree");
  a_req_drop_ack: assert property ((irqReq && irqAck) |=> !irqReq)
    else $error("request held after ack");
  // Nesting disabled may lift a user ack to level 7 instead
  a_level_on_ack: assert property ((irqReq && irqAck) |=>
    (cpuLevel == $past(irqLevel)) || (!$past(irqLevel[3]) && cpuLevel == 4'h7))
    else $error("cpu level not taken from ack");
endmodule // icsc_props

bind icsc_interrupt_control_status icsc_props icsc_props_i (
  .ref_clk(ref_clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .irqAck(irqAck), .irqReq(irqReq),
  .irqVector(irqVector), .irqLevel(irqLevel), .cpuLevel(cpuLevel));

// ---- inc/icsc_consts.vh ----
// Purpose: Register map, field positions and reset values of the interrupt control block
// Assumes: 32-bit classic Wishbone, one aligned word per 16-bit register
// Notes:   Definitions only
`ifndef ICSC_CONSTS_VH
`define ICSC_CONSTS_VH

// Register byte addresses
`define ICSC_ADR_ALU_STATUS   8'h00
`define ICSC_ADR_CORE_CTRL    8'h04
`define ICSC_ADR_INT_CTRL1    8'h08
`define ICSC_ADR_INT_CTRL2    8'h0c
`define ICSC_ADR_INT_CTRL3    8'h10
`define ICSC_ADR_INT_CTRL4    8'h14
`define ICSC_ADR_VEC_STATUS   8'h18
`define ICSC_ADR_FLAG0        8'h20
`define ICSC_ADR_ENABLE0      8'h24
`define ICSC_ADR_PRIO0        8'h28
`define ICSC_ADR_PRIO1        8'h2c
`define ICSC_ADR_PRIO2        8'h30
`define ICSC_ADR_PRIO3        8'h34

// Field positions
`define ICSC_CPL_LSB          5
`define ICSC_CPL_MSB          7
`define ICSC_PLMSB_BIT        3
`define ICSC_NESTING_DISABLE_BIT       15
`define ICSC_MATH_BIT         4
`define ICSC_ADDR_BIT         3
`define ICSC_STACK_BIT        2
`define ICSC_OSC_BIT          1
`define ICSC_GIE_BIT          15
`define ICSC_DISABLE_INSTR_ACTIVE_BIT         14
`define ICSC_SOFT_TRAP_STATUS_BIT       13
`define ICSC_ALTERNATE_VECTOR_TABLE_BIT         8
`define ICSC_DMT_BIT          15
`define ICSC_ECC_BIT          1
`define ICSC_SW_HARD_TRAP_FLAG_BIT         0
`define ICSC_CPU_REQUEST_PENDING_BIT       15
`define ICSC_VECTOR_CAPTURE_SELECT_BIT        13

// Reset values
`define ICSC_RST_CTRL2        16'h8000
`define ICSC_RST_ZERO16       16'h0000

// Vector numbers
`define ICSC_VEC_OSC          8'h00
`define ICSC_VEC_ADDR         8'h01
`define ICSC_VEC_HARD         8'h02
`define ICSC_VEC_STACK        8'h03
`define ICSC_VEC_MATH         8'h04
`define ICSC_VEC_SOFT         8'h06
`define ICSC_VEC_USER_BASE    8'h08

// Levels
`define ICSC_LVL_BLOCK_USER   3'h7
`define ICSC_LVL_TRAP_BASE    4'h8

// Synchroniser fill count before pin edges count
`define ICSC_SYNC_WARM        2'h3
`define ICSC_SYNC_STEP        2'h1

`endif

// ---- src/icsc_interrupt_control_status.v ----
// Purpose: Interrupt control and status logic: flags, enables, priorities, traps, CPU level
// Assumes: Single clock, classic Wishbone slave, CPU core on the same clock
// Notes:   Sixteen user sources, external interrupts 0..4 on sources 0..4
//
// Implementation choices: the register offsets and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "icsc_consts.vh"

module icsc_interrupt_control_status #(
  parameter NUM_SRC = 16,
  parameter NUM_EXT = 5
) (
  // Clock and reset
  input  wire                 ref_clk,
  input  wire                 rst_n,
  // Wishbone slave
  input  wire                 wb_cyc_i,
  input  wire                 wb_stb_i,
  input  wire                 wb_we_i,
  input  wire [7:0]           wb_adr_i,
  input  wire [3:0]           wb_sel_i,
  input  wire [31:0]          wb_dat_i,
  output wire [31:0]          wb_dat_o,
  output wire                 wb_ack_o,
  // Event sources
  input  wire [NUM_EXT-1:0]   extIrqPin,
  input  wire [NUM_SRC-1:0]   srcEvent,
  input  wire                 mathTrapEvt,
  input  wire                 addrTrapEvt,
  input  wire                 stackTrapEvt,
  input  wire                 oscTrapEvt,
  input  wire                 deadmanTrapEvt,
  input  wire                 eccTrapEvt,
  input  wire                 swHardTrapEvt,
  // CPU core side
  input  wire                 disiActive,
  input  wire                 altTableAllowed,
  input  wire                 irqAck,
  input  wire                 cpuLevelLoad,
  input  wire [3:0]           cpuLevelIn,
  output wire                 irqReq,
  output wire [7:0]           irqVector,
  output wire [3:0]           irqLevel,
  output wire [3:0]           cpuLevel,
  output wire                 useAltTable
);

  // Byte-lane merge of a 16-bit register write
  function [15:0] laneMerge;
    input [15:0] oldVal;
    input [15:0] newVal;
    input [1:0]  sel;
    reg   [15:0] mask;
    begin
      mask = {{8{sel[1]}}, {8{sel[0]}}};
      laneMerge = (oldVal & ~mask) | (newVal & mask);
    end
  endfunction

  // Software cannot set a clear-only bit, only clear it
  function [15:0] clearOnly;
    input [15:0] oldVal;
    input [15:0] merged;
    begin
      clearOnly = oldVal & merged;
    end
  endfunction

  // State
  reg                 ackFf;
  reg  [31:0]         rdDataFf;
  reg  [2:0]          cplLowFf;
  reg                 plMsbFf;
  reg  [15:0]         ctrl1Ff;
  reg  [15:0]         ctrl2Ff;
  reg                 deadmanFf;
  reg  [1:0]          ctrl4Ff;
  reg                 vholdFf;
  reg  [7:0]          vecNumFf;
  reg  [3:0]          newLvlFf;
  reg                 cpuReqPendFf;
  reg  [7:0]          ackVecFf;
  reg  [15:0]         flagFf;
  reg  [15:0]         enableFf;
  reg  [63:0]         prioFf;
  reg  [NUM_EXT-1:0]  extSyncAFf;
  reg  [NUM_EXT-1:0]  extSyncBFf;
  reg  [NUM_EXT-1:0]  extPrevFf;
  reg  [1:0]          syncWarmFf;
  reg                 irqReqFf;
  reg  [7:0]          irqVecFf;
  reg  [3:0]          irqLvlFf;

  // Combinational
  reg  [31:0]         nxt_rdData;
  reg  [15:0]         nxt_flag;
  reg  [3:0]          bestPrio;
  reg  [7:0]          bestVec;
  reg                 bestValid;
  reg                 anyCand;
  reg  [3:0]          trapLvl;
  reg  [7:0]          trapVec;
  reg                 trapValid;
  integer             i;

  wire                wbReq;
  wire                wbWr;
  wire [15:0]         wrData;
  wire [1:0]          wrSel;
  wire [NUM_EXT-1:0]  extEdge;
  wire [15:0]         ctrl4Wr;
  wire [15:0]         hwSet;
  wire                userBlocked;
  wire [2:0]          trapFlags1;
  wire                hardTrap;
  wire                softTrap;
  wire                reqValid;
  wire [7:0]          reqVec;
  wire [3:0]          reqLvl;

  // Bus handshake: ack one cycle after the strobe, write lands on the ack edge
  assign wbReq    = wb_cyc_i & wb_stb_i;
  assign wbWr     = wbReq & wb_we_i & ackFf;
  assign wrData   = wb_dat_i[15:0];
  assign wrSel    = wb_sel_i[1:0];
  assign wb_ack_o = ackFf;
  assign wb_dat_o = rdDataFf;

  // Level seen by arbitration
  assign cpuLevel = {plMsbFf, cplLowFf};

  // Users blocked by level bits or by the global enable
  assign userBlocked = plMsbFf
                     | (cplLowFf == `ICSC_LVL_BLOCK_USER)
                     | ~ctrl2Ff[`ICSC_GIE_BIT];

  // Selected edge on synchronised pin, polarity one means falling;
  // held off until the stages hold real pin levels, else a pin idling high fakes an edge
  assign extEdge = (extSyncBFf ^ extPrevFf)
                 & (extSyncBFf ^ ctrl2Ff[NUM_EXT-1:0])
                 & {NUM_EXT{syncWarmFf == `ICSC_SYNC_WARM}};

  // Hardware set terms: external pins on the lowest sources
  assign hwSet = srcEvent | {{(16-NUM_EXT){1'b0}}, extEdge};

  assign useAltTable = ctrl2Ff[`ICSC_ALTERNATE_VECTOR_TABLE_BIT] & altTableAllowed;

  // Trap grouping onto the generic vectors
  assign trapFlags1 = {ctrl1Ff[`ICSC_ADDR_BIT], ctrl1Ff[`ICSC_STACK_BIT], ctrl1Ff[`ICSC_MATH_BIT]};
  assign hardTrap   = ctrl4Ff[`ICSC_ECC_BIT] | ctrl4Ff[`ICSC_SW_HARD_TRAP_FLAG_BIT];
  assign softTrap   = deadmanFf | ctrl2Ff[`ICSC_SOFT_TRAP_STATUS_BIT];

  // Clear-only write value of control four
  assign ctrl4Wr = clearOnly({14'h0000, ctrl4Ff}, laneMerge({14'h0000, ctrl4Ff}, wrData, wrSel));

  // User arbitration: highest priority, lowest vector on a tie
  always @*
  begin
    bestPrio  = 4'h0;
    bestVec   = `ICSC_VEC_USER_BASE;
    bestValid = 1'b0;
    anyCand   = 1'b0;
    for (i = 0; i < NUM_SRC; i = i + 1)
    begin
      if (flagFf[i] && enableFf[i] && ctrl2Ff[`ICSC_GIE_BIT])
      begin
        anyCand = 1'b1;
        if ({1'b0, prioFf[i*4 +: 3]} > bestPrio)
        begin
          bestPrio  = {1'b0, prioFf[i*4 +: 3]};
          bestVec   = `ICSC_VEC_USER_BASE + i[7:0];
          bestValid = 1'b1;
        end
      end
    end
  end

  // Trap arbitration: lower vector ranks higher, level above any user level
  always @*
  begin
    trapValid = 1'b1;
    trapVec   = `ICSC_VEC_OSC;
    trapLvl   = `ICSC_LVL_TRAP_BASE + 4'h7;
    if (ctrl1Ff[`ICSC_OSC_BIT])
    begin
      trapVec = `ICSC_VEC_OSC;
      trapLvl = `ICSC_LVL_TRAP_BASE + 4'h7;
    end
    else if (trapFlags1[2])
    begin
      trapVec = `ICSC_VEC_ADDR;
      trapLvl = `ICSC_LVL_TRAP_BASE + 4'h6;
    end
    else if (hardTrap)
    begin
      trapVec = `ICSC_VEC_HARD;
      trapLvl = `ICSC_LVL_TRAP_BASE + 4'h5;
    end
    else if (trapFlags1[1])
    begin
      trapVec = `ICSC_VEC_STACK;
      trapLvl = `ICSC_LVL_TRAP_BASE + 4'h4;
    end
    else if (trapFlags1[0])
    begin
      trapVec = `ICSC_VEC_MATH;
      trapLvl = `ICSC_LVL_TRAP_BASE + 4'h3;
    end
    else if (softTrap)
    begin
      trapVec = `ICSC_VEC_SOFT;
      trapLvl = `ICSC_LVL_TRAP_BASE;
    end
    else
    begin
      trapValid = 1'b0;
    end
  end

  // Traps ignore the global enable and the level high bit, only the level itself
  assign reqValid = (trapValid && (trapLvl > cpuLevel))
                  | (bestValid && !userBlocked && (bestPrio > cpuLevel));
  assign reqVec   = (trapValid && (trapLvl > cpuLevel)) ? trapVec : bestVec;
  assign reqLvl   = (trapValid && (trapLvl > cpuLevel)) ? trapLvl : bestPrio;

  assign irqReq    = irqReqFf;
  assign irqVector = irqVecFf;
  assign irqLevel  = irqLvlFf;

  // Request flags: a hardware set wins over a clear in the same cycle
  always @*
  begin
    nxt_flag = flagFf;
    if (wbWr && (wb_adr_i == `ICSC_ADR_FLAG0))
    begin
      nxt_flag = laneMerge(flagFf, wrData, wrSel);
    end
    nxt_flag = nxt_flag | hwSet;
  end

  // Read data mux, unmapped addresses read zero
  always @*
  begin
    nxt_rdData = 32'h0000_0000;
    case (wb_adr_i)
      `ICSC_ADR_ALU_STATUS: nxt_rdData[`ICSC_CPL_MSB:`ICSC_CPL_LSB] = cplLowFf;
      `ICSC_ADR_CORE_CTRL:  nxt_rdData[`ICSC_PLMSB_BIT] = plMsbFf;
      `ICSC_ADR_INT_CTRL1:  nxt_rdData[15:0] = ctrl1Ff;
      `ICSC_ADR_INT_CTRL2:  nxt_rdData[15:0] = ctrl2Ff | {1'b0, disiActive, 14'h0000};
      `ICSC_ADR_INT_CTRL3:  nxt_rdData[`ICSC_DMT_BIT] = deadmanFf;
      `ICSC_ADR_INT_CTRL4:  nxt_rdData[1:0] = ctrl4Ff;
      `ICSC_ADR_VEC_STATUS: nxt_rdData[15:0] = {cpuReqPendFf, 1'b0, vholdFf, 1'b0,
                                                newLvlFf, vecNumFf};
      `ICSC_ADR_FLAG0:      nxt_rdData[15:0] = flagFf;
      `ICSC_ADR_ENABLE0:    nxt_rdData[15:0] = enableFf;
      `ICSC_ADR_PRIO0:      nxt_rdData[15:0] = prioFf[15:0];
      `ICSC_ADR_PRIO1:      nxt_rdData[15:0] = prioFf[31:16];
      `ICSC_ADR_PRIO2:      nxt_rdData[15:0] = prioFf[47:32];
      `ICSC_ADR_PRIO3:      nxt_rdData[15:0] = prioFf[63:48];
      default:              nxt_rdData = 32'h0000_0000;
    endcase
  end

  // Bus slave registers
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ackFf    <= 1'b0;
      rdDataFf <= 32'h0000_0000;
    end
    else
    begin
      ackFf <= wbReq & ~ackFf;
      if (wbReq && !ackFf)
        rdDataFf <= nxt_rdData;
    end
  end

  // Pin synchronisers: first stage read only by the second
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      extSyncAFf <= {NUM_EXT{1'b0}};
      extSyncBFf <= {NUM_EXT{1'b0}};
      extPrevFf  <= {NUM_EXT{1'b0}};
      syncWarmFf <= 2'h0;
    end
    else
    begin
      if (syncWarmFf != `ICSC_SYNC_WARM)
        syncWarmFf <= syncWarmFf + `ICSC_SYNC_STEP;
      extSyncAFf <= extIrqPin;
      extSyncBFf <= extSyncAFf;
      extPrevFf  <= extSyncBFf;
    end
  end

  // Flags, enables and priorities
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      flagFf   <= `ICSC_RST_ZERO16;
      enableFf <= `ICSC_RST_ZERO16;
      prioFf   <= 64'h0000_0000_0000_0000;
    end
    else
    begin
      flagFf <= nxt_flag;
      if (wbWr && (wb_adr_i == `ICSC_ADR_ENABLE0))
        enableFf <= laneMerge(enableFf, wrData, wrSel);
      // Reserved bit 3 of each nibble stays zero
      if (wbWr && (wb_adr_i == `ICSC_ADR_PRIO0))
        prioFf[15:0]  <= laneMerge(prioFf[15:0], wrData, wrSel) & 16'h7777;
      if (wbWr && (wb_adr_i == `ICSC_ADR_PRIO1))
        prioFf[31:16] <= laneMerge(prioFf[31:16], wrData, wrSel) & 16'h7777;
      if (wbWr && (wb_adr_i == `ICSC_ADR_PRIO2))
        prioFf[47:32] <= laneMerge(prioFf[47:32], wrData, wrSel) & 16'h7777;
      if (wbWr && (wb_adr_i == `ICSC_ADR_PRIO3))
        prioFf[63:48] <= laneMerge(prioFf[63:48], wrData, wrSel) & 16'h7777;
    end
  end

  // Control registers and trap flags; trap events win over software clears
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      ctrl1Ff   <= `ICSC_RST_ZERO16;
      ctrl2Ff   <= `ICSC_RST_CTRL2;
      deadmanFf <= 1'b0;
      ctrl4Ff   <= 2'h0;
      vholdFf   <= 1'b0;
    end
    else
    begin
      if (wbWr && (wb_adr_i == `ICSC_ADR_INT_CTRL1))
        ctrl1Ff <= (laneMerge(ctrl1Ff, wrData, wrSel) & 16'h801e)
                 | {11'h000, mathTrapEvt, addrTrapEvt, stackTrapEvt, oscTrapEvt, 1'b0};
      else
        ctrl1Ff <= ctrl1Ff
                 | {11'h000, mathTrapEvt, addrTrapEvt, stackTrapEvt, oscTrapEvt, 1'b0};
      // Bit 14 is never stored; it reflects the core live
      if (wbWr && (wb_adr_i == `ICSC_ADR_INT_CTRL2))
        ctrl2Ff <= laneMerge(ctrl2Ff, wrData, wrSel) & 16'ha11f;
      if (wbWr && (wb_adr_i == `ICSC_ADR_INT_CTRL3) && wrSel[1])
        deadmanFf <= wrData[`ICSC_DMT_BIT] | deadmanTrapEvt;
      else
        deadmanFf <= deadmanFf | deadmanTrapEvt;
      if (wbWr && (wb_adr_i == `ICSC_ADR_INT_CTRL4))
        ctrl4Ff <= ctrl4Wr[1:0] | {eccTrapEvt, swHardTrapEvt};
      else
        ctrl4Ff <= ctrl4Ff | {eccTrapEvt, swHardTrapEvt};
      if (wbWr && (wb_adr_i == `ICSC_ADR_VEC_STATUS) && wrSel[1])
        vholdFf <= wrData[`ICSC_VECTOR_CAPTURE_SELECT_BIT];
    end
  end

  // CPU level: acknowledge and core restore load it, software writes steer it
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      cplLowFf <= 3'h0;
      plMsbFf  <= 1'b0;
    end
    else if (irqAck && irqReqFf)
    begin
      // With nesting off a user handler runs at level 7 so nothing user can preempt
      if (ctrl1Ff[`ICSC_NESTING_DISABLE_BIT] && !irqLvlFf[3])
        cplLowFf <= `ICSC_LVL_BLOCK_USER;
      else
        cplLowFf <= irqLvlFf[2:0];
      plMsbFf <= irqLvlFf[3];
    end
    else if (cpuLevelLoad)
    begin
      cplLowFf <= cpuLevelIn[2:0];
      plMsbFf  <= cpuLevelIn[3];
    end
    else
    begin
      if (wbWr && (wb_adr_i == `ICSC_ADR_ALU_STATUS) && wrSel[0]
          && !ctrl1Ff[`ICSC_NESTING_DISABLE_BIT])
        cplLowFf <= wrData[`ICSC_CPL_MSB:`ICSC_CPL_LSB];
      if (wbWr && (wb_adr_i == `ICSC_ADR_CORE_CTRL) && wrSel[0])
        plMsbFf <= plMsbFf & wrData[`ICSC_PLMSB_BIT];
    end
  end

  // Request to the CPU and status capture
  always @(posedge ref_clk)
  begin
    if (!rst_n)
    begin
      irqReqFf     <= 1'b0;
      irqVecFf     <= 8'h00;
      irqLvlFf     <= 4'h0;
      ackVecFf     <= 8'h00;
      vecNumFf     <= 8'h00;
      newLvlFf     <= 4'h0;
      cpuReqPendFf <= 1'b0;
    end
    else
    begin
      irqReqFf <= reqValid & ~(irqAck & irqReqFf);
      irqVecFf <= reqVec;
      irqLvlFf <= reqLvl;
      if (irqAck && irqReqFf)
        ackVecFf <= irqVecFf;
      // Capture select picks live pending or last acknowledged
      vecNumFf <= vholdFf ? reqVec : ((irqAck && irqReqFf) ? irqVecFf : ackVecFf);
      newLvlFf <= reqLvl;
      // Waiting source held back by the CPU level, or a request the CPU has not yet acknowledged
      cpuReqPendFf <= (anyCand && !reqValid) | (irqReqFf && !irqAck);
    end
  end

endmodule // icsc_interrupt_control_status
